/* File: flag_cell.sv */
// One sticky interrupt flag: hardware sets, software writes.
// Assumes set and write come from logic on the same clock.
`default_nettype none
module flag_cell (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Controls
  input wire logic hw_set,
  input wire logic sw_write,
  input wire logic sw_value,
  // State
  output logic flag
);
  wire next_flag = hw_set | (sw_write ? sw_value : flag); // [RULE19]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag <= 1'b0; // [RULE16]
    end else begin
      flag <= next_flag;
    end
  end
endmodule : flag_cell
`default_nettype wire

/* File: irq_flag_bank_defs.svh */
// Register map, field positions and reset values of the peripheral interrupt flag bank.
// Assumes a 32-bit AXI4-Lite bus in front of it; byte addresses are word aligned.
// How it works
// [RULE1] Zero-cross flag, bit 6, sets on an enabled edge and holds until cleared.
// [RULE2] Comparator flags, bits 1 and 0, set on comparator interrupt, held until cleared.
// [RULE3] Receive flags, bits 7 and 5, read one while the receive buffer holds data.
// [RULE4] Receive flags are read-only and clear only once the receive buffer is drained.
// [RULE5] Transmit flags, bits 6 and 4, read one while the transmit buffer has room.
// [RULE6] Transmit flags are read-only and clear only when the transmit buffer is full.
// [RULE7] Software must not write transmit data while the transmit flag reads zero.
// [RULE8] Transmit flags show buffer room only; shift-register-empty is reported separately.
// [RULE9] Collision flags, bits 3 and 1, set on bus collision, held until cleared.
// [RULE10] Sync port event flags, bits 2 and 0, set on completion, held until cleared.
// [RULE11] Period timer flag sets on postscaler overflow, or on period match at 1:1.
// [RULE12] Wide timer overflow flag, bit 0, sets on overflow, held until cleared.
// [RULE13] Logic cell flags, bits 7 to 4, set on cell interrupt, held until cleared.
// [RULE14] Timer gate flag, bit 0, sets when the gate goes inactive.
// [RULE15] Capture/compare flags set on capture, match or trailing edge per unit mode.
// [RULE16] Every writable flag resets to zero on every reset; the read-only transmit flags read one after reset while the buffer has room.
// [RULE17] Unimplemented flag positions always read zero.
// [RULE18] No flag raises the interrupt unless peripheral enable and its own enable are set.
// [RULE19] A hardware set wins over a software clear in the same cycle.
`ifndef IRQ_FLAG_BANK_DEFS_SVH
`define IRQ_FLAG_BANK_DEFS_SVH

`define ADDR_FLAGS_ANALOG 8'h00
`define ADDR_FLAGS_SERIAL 8'h04
`define ADDR_FLAGS_TIMERS 8'h08
`define ADDR_FLAGS_LOGIC 8'h0c
`define ADDR_FLAGS_CAPCMP 8'h10
`define ADDR_ENABLE_BASE 8'h20
`define ADDR_CONTROL 8'h40
`define ADDR_SERIAL_STATUS 8'h44
`define ADDR_EVENT_STATUS 8'h48
`define ADDR_EVENT_MASK 8'h4c

`define NUM_FLAG_REGS 5
`define FLAG_W 8
`define FLAG_REG_RESET 8'h00
`define FLAG_WR_MASK 40'h03_f1_03_0f_43
`define FLAG_RO_MASK 40'h00_00_00_f0_00

`define BIT_ZERO_CROSS 6
`define BIT_COMP_B 1
`define BIT_COMP_A 0
`define BIT_UART_B_RX 7
`define BIT_UART_B_TX 6
`define BIT_UART_A_RX 5
`define BIT_UART_A_TX 4
`define BIT_SYNC_B_COLL 3
`define BIT_SYNC_B_EVT 2
`define BIT_SYNC_A_COLL 1
`define BIT_SYNC_A_EVT 0
`define BIT_PERIOD_TIMER 1
`define BIT_WIDE_TIMER 0
`define BIT_LOGIC_LO 4
`define BIT_GATE_DONE 0
`define BIT_CAPCMP_B 1
`define BIT_CAPCMP_A 0

`define CTRL_PERIPH_IRQ_EN 0
`define CTRL_ZC_RISE_EN 1
`define CTRL_ZC_FALL_EN 2
`define CTRL_W 3
`define CTRL_RESET 3'h0
`define EVT_RESET 5'h00

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* File: irq_flag_bank_pkg.sv */
// Types shared by the peripheral interrupt flag bank.
// Assumes the defines header is compiled alongside.
`default_nettype none
package irq_flag_bank_pkg;
  // Capture/compare unit operating mode
  typedef enum logic [1:0] {
    CAPCMP_OFF = 2'h0,
    CAPCMP_CAPTURE = 2'h1,
    CAPCMP_COMPARE = 2'h2,
    CAPCMP_PWM = 2'h3
  } capcmp_mode_t;
endpackage : irq_flag_bank_pkg
`default_nettype wire

/* File: periph_event_model.sv */
// Peripheral side of the flag bank: event pulses and serial buffer levels.
// Assumes bench commands are one-cycle pulses on aclk that never overflow or underflow a buffer.
`default_nettype none
module periph_event_model #(
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench commands: rx push, rx pop, tx write, tx drain, two bits each
  input wire logic [20:0] fire,
  input wire logic [7:0] cmd,
  // Event pulses
  output logic [20:0] pulse,
  // Serial buffer levels, one bit a port
  output logic [1:0] rx_not_empty,
  output logic [1:0] tx_has_room,
  output logic [1:0] tx_shift_empty
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] rx_cnt [2];
  logic [1:0] tx_cnt [2];
  assign pulse = fire;
  always_ff @(posedge aclk) begin
    for (int p = 0; p < 2; p++) begin
      if (!aresetn) begin
        rx_cnt[p] <= 2'h0;
        tx_cnt[p] <= 2'h0;
      end else begin
        rx_cnt[p] <= rx_cnt[p] + 2'(cmd[p]) - 2'(cmd[p+2]);
        tx_cnt[p] <= tx_cnt[p] + 2'(cmd[p+4]) - 2'(cmd[p+6]);
      end
    end
  end
  // Shifter counts as idle only while nothing waits in the buffer
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      rx_not_empty[p] = (rx_cnt[p] != 2'h0);
      tx_has_room[p] = (int'(tx_cnt[p]) < DEPTH);
      tx_shift_empty[p] = (tx_cnt[p] == 2'h0);
    end
  end
endmodule : periph_event_model
`default_nettype wire

/* File: peripheral_irq_flag_bank.sv */
// Five peripheral interrupt flag registers with enables, event log and one interrupt output.
// Assumes peripheral event inputs are single-cycle pulses and levels on aclk.
`include "irq_flag_bank_defs.svh"
`default_nettype none
module peripheral_irq_flag_bank
  import irq_flag_bank_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog events
  input wire logic zero_cross_rise,
  input wire logic zero_cross_fall,
  input wire logic comparator_a_event,
  input wire logic comparator_b_event,
  // Serial port buffer state
  input wire logic uart_a_rx_not_empty,
  input wire logic uart_b_rx_not_empty,
  input wire logic uart_a_tx_has_room,
  input wire logic uart_b_tx_has_room,
  input wire logic uart_a_tx_shift_empty,
  input wire logic uart_b_tx_shift_empty,
  // Synchronous serial port events
  input wire logic sync_port_a_collision,
  input wire logic sync_port_a_done,
  input wire logic sync_port_b_collision,
  input wire logic sync_port_b_done,
  // Timer events
  input wire logic period_match,
  input wire logic postscaler_overflow,
  input wire logic postscale_one_to_one,
  input wire logic wide_timer_overflow,
  input wire logic timer_gate_active,
  // Logic cell events, cell d down to cell a
  input wire logic [3:0] logic_cell_event,
  // Capture/compare units
  input wire capcmp_mode_t capcmp_a_mode,
  input wire logic capcmp_a_capture,
  input wire logic capcmp_a_match,
  input wire logic capcmp_a_trailing_edge,
  input wire capcmp_mode_t capcmp_b_mode,
  input wire logic capcmp_b_capture,
  input wire logic capcmp_b_match,
  input wire logic capcmp_b_trailing_edge,
  // Interrupt
  output logic irq
);
  localparam int NF = `NUM_FLAG_REGS * `FLAG_W;
  localparam logic [NF-1:0] WR_MASK = `FLAG_WR_MASK;
  localparam logic [NF-1:0] RO_MASK = `FLAG_RO_MASK;
  localparam logic [NF-1:0] IMPL_MASK = WR_MASK | RO_MASK;

  // Register state
  logic [NF-1:0] flag_q;
  logic [NF-1:0] enable_q;
  logic [`CTRL_W-1:0] control;
  logic [`NUM_FLAG_REGS-1:0] event_status;
  logic [`NUM_FLAG_REGS-1:0] event_mask;
  logic [NF-1:0] flags_prev;
  logic gate_prev;

  // Bus state
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Flag sources
  wire peripheral_irq_enable = control[`CTRL_PERIPH_IRQ_EN];
  wire zc_set = (zero_cross_rise & control[`CTRL_ZC_RISE_EN]) |
                (zero_cross_fall & control[`CTRL_ZC_FALL_EN]); // [RULE1]
  wire period_set = postscale_one_to_one ? period_match : postscaler_overflow; // [RULE11]
  wire gate_done = gate_prev & ~timer_gate_active; // [RULE14]

  function automatic logic capcmp_set(input capcmp_mode_t mode, input logic cap, input logic mat,
                                      input logic edge_seen);
    logic r;
    r = 1'b0;
    case (mode)
      CAPCMP_CAPTURE: r = cap;
      CAPCMP_COMPARE: r = mat;
      CAPCMP_PWM: r = edge_seen;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : capcmp_set

  wire capcmp_a_set = capcmp_set(capcmp_a_mode, capcmp_a_capture, capcmp_a_match,
                                 capcmp_a_trailing_edge); // [RULE15]
  wire capcmp_b_set = capcmp_set(capcmp_b_mode, capcmp_b_capture, capcmp_b_match,
                                 capcmp_b_trailing_edge); // [RULE15]

  logic [`FLAG_W-1:0] set_analog;
  logic [`FLAG_W-1:0] set_serial;
  logic [`FLAG_W-1:0] set_timers;
  logic [`FLAG_W-1:0] set_logic;
  logic [`FLAG_W-1:0] set_capcmp;
  logic [`FLAG_W-1:0] lvl_serial;

  always_comb begin
    set_analog = `FLAG_REG_RESET;
    set_analog[`BIT_ZERO_CROSS] = zc_set; // [RULE1]
    set_analog[`BIT_COMP_B] = comparator_b_event; // [RULE2]
    set_analog[`BIT_COMP_A] = comparator_a_event; // [RULE2]
    set_serial = `FLAG_REG_RESET;
    set_serial[`BIT_SYNC_B_COLL] = sync_port_b_collision; // [RULE9]
    set_serial[`BIT_SYNC_A_COLL] = sync_port_a_collision; // [RULE9]
    set_serial[`BIT_SYNC_B_EVT] = sync_port_b_done; // [RULE10]
    set_serial[`BIT_SYNC_A_EVT] = sync_port_a_done; // [RULE10]
    set_timers = `FLAG_REG_RESET;
    set_timers[`BIT_PERIOD_TIMER] = period_set; // [RULE11]
    set_timers[`BIT_WIDE_TIMER] = wide_timer_overflow; // [RULE12]
    set_logic = `FLAG_REG_RESET;
    set_logic[`BIT_LOGIC_LO +: 4] = logic_cell_event; // [RULE13]
    set_logic[`BIT_GATE_DONE] = gate_done; // [RULE14]
    set_capcmp = `FLAG_REG_RESET;
    set_capcmp[`BIT_CAPCMP_B] = capcmp_b_set; // [RULE15]
    set_capcmp[`BIT_CAPCMP_A] = capcmp_a_set; // [RULE15]
    // Buffer-occupancy levels; room, not completion, drives the transmit bits
    lvl_serial = `FLAG_REG_RESET;
    lvl_serial[`BIT_UART_B_RX] = uart_b_rx_not_empty; // [RULE3] [RULE4]
    lvl_serial[`BIT_UART_A_RX] = uart_a_rx_not_empty; // [RULE3] [RULE4]
    lvl_serial[`BIT_UART_B_TX] = uart_b_tx_has_room; // [RULE5] [RULE6] [RULE8]
    lvl_serial[`BIT_UART_A_TX] = uart_a_tx_has_room; // [RULE5] [RULE6] [RULE8]
  end

  wire [NF-1:0] hw_set = {set_capcmp, set_logic, set_timers, set_serial, set_analog};
  wire [NF-1:0] ro_level = {{(NF - 2 * `FLAG_W){1'b0}}, lvl_serial, {`FLAG_W{1'b0}}};
  wire [NF-1:0] flags = ((flag_q & WR_MASK) | (ro_level & RO_MASK)) & IMPL_MASK; // [RULE17]

  // Write decode
  wire do_write = aw_held & w_held & ~s_axi_bvalid;
  wire byte0 = w_strb[0];
  wire [ADDR_W-1:0] en_last = ADDR_W'(`ADDR_ENABLE_BASE + 8'h10);
  wire wr_is_flag = (aw_addr <= ADDR_W'(`ADDR_FLAGS_CAPCMP)) && (aw_addr[1:0] == 2'b00);
  wire wr_is_enable = (aw_addr >= ADDR_W'(`ADDR_ENABLE_BASE)) && (aw_addr <= en_last) &&
                      (aw_addr[1:0] == 2'b00);
  wire wr_is_ctrl = aw_addr == ADDR_W'(`ADDR_CONTROL);
  wire wr_is_mask = aw_addr == ADDR_W'(`ADDR_EVENT_MASK);
  wire wr_is_ro = (aw_addr == ADDR_W'(`ADDR_SERIAL_STATUS)) || (aw_addr == ADDR_W'(`ADDR_EVENT_STATUS));
  wire wr_ok = wr_is_flag | wr_is_enable | wr_is_ctrl | wr_is_mask | wr_is_ro;
  wire [2:0] wr_flag_idx = aw_addr[4:2];
  wire [ADDR_W-1:0] en_off = aw_addr - ADDR_W'(`ADDR_ENABLE_BASE);
  wire [2:0] wr_en_idx = en_off[4:2];

  logic [NF-1:0] flag_wr;
  logic [NF-1:0] enable_wr;
  always_comb begin
    flag_wr = '0;
    enable_wr = '0;
    for (int r = 0; r < `NUM_FLAG_REGS; r++) begin
      if (do_write && byte0 && wr_is_flag && (wr_flag_idx == 3'(r))) begin
        flag_wr[r*`FLAG_W +: `FLAG_W] = {`FLAG_W{1'b1}};
      end
      if (do_write && byte0 && wr_is_enable && (wr_en_idx == 3'(r))) begin
        enable_wr[r*`FLAG_W +: `FLAG_W] = {`FLAG_W{1'b1}};
      end
    end
  end
  wire [NF-1:0] wr_value = {`NUM_FLAG_REGS{w_data[`FLAG_W-1:0]}};

  // Writable flags; read-only positions get no storage
  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++) begin : g_flag
      if (WR_MASK[gi]) begin : g_cell
        flag_cell u_cell (
          .aclk(aclk),
          .aresetn(aresetn),
          .hw_set(hw_set[gi]), // [RULE19]
          .sw_write(flag_wr[gi]),
          .sw_value(wr_value[gi]),
          .flag(flag_q[gi])
        );
      end else begin : g_none
        assign flag_q[gi] = 1'b0;
      end
    end
  endgenerate

  // Read decode
  wire rd_take = s_axi_arvalid & s_axi_arready;
  wire [ADDR_W-1:0] rd_en_off = s_axi_araddr - ADDR_W'(`ADDR_ENABLE_BASE);
  wire rd_is_flag = (s_axi_araddr <= ADDR_W'(`ADDR_FLAGS_CAPCMP)) && (s_axi_araddr[1:0] == 2'b00);
  wire rd_is_enable = (s_axi_araddr >= ADDR_W'(`ADDR_ENABLE_BASE)) && (s_axi_araddr <= en_last) &&
                      (s_axi_araddr[1:0] == 2'b00);
  wire rd_is_ctrl = s_axi_araddr == ADDR_W'(`ADDR_CONTROL);
  wire rd_is_sstat = s_axi_araddr == ADDR_W'(`ADDR_SERIAL_STATUS);
  wire rd_is_evt = s_axi_araddr == ADDR_W'(`ADDR_EVENT_STATUS);
  wire rd_is_mask = s_axi_araddr == ADDR_W'(`ADDR_EVENT_MASK);
  wire rd_ok = rd_is_flag | rd_is_enable | rd_is_ctrl | rd_is_sstat | rd_is_evt | rd_is_mask;
  wire [2:0] rd_flag_idx = s_axi_araddr[4:2];
  wire [2:0] rd_en_idx = rd_en_off[4:2];

  logic [31:0] rd_value;
  always_comb begin
    rd_value = 32'h0000_0000;
    for (int r = 0; r < `NUM_FLAG_REGS; r++) begin
      if (rd_is_flag && (rd_flag_idx == 3'(r))) begin
        rd_value[`FLAG_W-1:0] = flags[r*`FLAG_W +: `FLAG_W]; // [RULE17]
      end
      if (rd_is_enable && (rd_en_idx == 3'(r))) begin
        rd_value[`FLAG_W-1:0] = enable_q[r*`FLAG_W +: `FLAG_W];
      end
    end
    if (rd_is_ctrl) begin
      rd_value[`CTRL_W-1:0] = control;
    end
    if (rd_is_sstat) begin
      rd_value[1:0] = {uart_b_tx_shift_empty, uart_a_tx_shift_empty}; // [RULE8]
    end
    if (rd_is_evt) begin
      rd_value[`NUM_FLAG_REGS-1:0] = event_status;
    end
    if (rd_is_mask) begin
      rd_value[`NUM_FLAG_REGS-1:0] = event_mask;
    end
  end

  // Event log: a newly raised enabled flag sets its register's bit
  logic [`NUM_FLAG_REGS-1:0] evt_hit;
  always_comb begin
    for (int r = 0; r < `NUM_FLAG_REGS; r++) begin
      evt_hit[r] = |(flags[r*`FLAG_W +: `FLAG_W] & ~flags_prev[r*`FLAG_W +: `FLAG_W] &
                     enable_q[r*`FLAG_W +: `FLAG_W]); // [RULE18]
    end
  end
  wire evt_clear = rd_take & rd_is_evt;
  wire [`NUM_FLAG_REGS-1:0] next_event_status =
    evt_hit | (evt_clear ? `EVT_RESET : event_status); // [RULE19]

  assign irq = peripheral_irq_enable & |(event_status & event_mask); // [RULE18]

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= '0;
      control <= `CTRL_RESET;
      event_mask <= `EVT_RESET;
      event_status <= `EVT_RESET;
      flags_prev <= '0;
      gate_prev <= 1'b0;
    end else begin
      enable_q <= (enable_q & ~enable_wr) | (wr_value & enable_wr & IMPL_MASK);
      if (do_write && byte0 && wr_is_ctrl) begin
        control <= w_data[`CTRL_W-1:0];
      end
      if (do_write && byte0 && wr_is_mask) begin
        event_mask <= w_data[`NUM_FLAG_REGS-1:0];
      end
      event_status <= next_event_status;
      flags_prev <= flags;
      gate_prev <= timer_gate_active;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire comp_clr = flag_wr[`BIT_COMP_A] & ~w_data[`BIT_COMP_A];
  chk_zero_cross_set: assert property ( // [RULE1]
    zero_cross_rise && control[`CTRL_ZC_RISE_EN] |=> flags[`BIT_ZERO_CROSS])
    else $error("zero-cross flag not set by enabled rising edge");
  chk_comparator_holds: assert property ( // [RULE2]
    comparator_a_event |=> flags[`BIT_COMP_A] [*2] or (flags[`BIT_COMP_A] ##1 $past(comp_clr)))
    else $error("comparator flag lost before software clear");
  chk_rx_follows_buffer: assert property ( // [RULE3]
    flags[`FLAG_W + `BIT_UART_A_RX] == uart_a_rx_not_empty &&
    flags[`FLAG_W + `BIT_UART_B_RX] == uart_b_rx_not_empty)
    else $error("receive flag does not follow receive buffer");
  chk_tx_follows_room: assert property ( // [RULE5]
    $fell(uart_a_tx_has_room) |-> !flags[`FLAG_W + `BIT_UART_A_TX])
    else $error("transmit flag set while buffer full");
  chk_collision_set_wins: assert property ( // [RULE19]
    sync_port_a_collision && flag_wr[`FLAG_W + `BIT_SYNC_A_COLL] |=> flags[`FLAG_W + `BIT_SYNC_A_COLL])
    else $error("software clear beat hardware collision set");
  chk_period_match_set: assert property ( // [RULE11]
    postscale_one_to_one && period_match |=> flags[2*`FLAG_W + `BIT_PERIOD_TIMER])
    else $error("period match at 1:1 did not set timer flag");
  chk_gate_done_set: assert property ( // [RULE14]
    $fell(timer_gate_active) |=> flags[3*`FLAG_W + `BIT_GATE_DONE])
    else $error("gate going inactive did not set gate flag");
  chk_irq_needs_enable: assert property ( // [RULE18]
    !peripheral_irq_enable |-> !irq)
    else $error("interrupt raised without peripheral enable");
  chk_rdata_upper_zero: assert property ( // [RULE17]
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("unimplemented read bits not zero");
  chk_capture_mode_set: assert property ( // [RULE15]
    capcmp_a_mode == CAPCMP_CAPTURE && capcmp_a_capture |=> flags[4*`FLAG_W + `BIT_CAPCMP_A])
    else $error("capture did not set capture/compare flag");

  cov_irq_raised: cover property (peripheral_irq_enable ##1 irq);
  cov_set_and_clear: cover property (sync_port_a_collision && flag_wr[`FLAG_W + `BIT_SYNC_A_COLL]);
  cov_event_read_clear: cover property (evt_clear && event_status != `EVT_RESET);
endmodule : peripheral_irq_flag_bank
`default_nettype wire

/* File: peripheral_irq_flag_bank_bench.sv */
// Self-checking bench of the flag bank over AXI4-Lite.
// Assumes the event model drives the event pulses and buffer levels, the bench drives mode, one-to-one and gate; buffer depth two.
`include "irq_flag_bank_defs.svh"
`default_nettype none
module peripheral_irq_flag_bank_bench import irq_flag_bank_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // Event code, mode, one-to-one, address, expected flags
  localparam logic [23:0] CASES [24] = '{24'h000040, 24'h080040, 24'h100001, 24'h180002, 24'h200452,
    24'h280451, 24'h300458, 24'h380454, 24'h410802, 24'h400800, 24'h480802, 24'h500801, 24'h5a1001,
    24'h641001, 24'h6e1001, 24'h621000, 24'h581000, 24'h721002, 24'h7c1002, 24'h861002, 24'h880c10,
    24'h900c20, 24'h980c40, 24'ha00c80};
  localparam logic [7:0] WR_EXP [5] = '{8'h43, 8'h5f, 8'h03, 8'hf1, 8'h03};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [20:0] fire = 21'h0;
  logic [20:0] pulse;
  logic [7:0] cmd = 8'h00;
  logic [1:0] rx_ne, tx_room, tx_se;
  logic os = 1'b0;
  logic gate = 1'b0;
  capcmp_mode_t mode = CAPCMP_OFF;
  int bad_count = 0;
  int num_checks = 0;

  initial begin
    forever #4 aclk = ~aclk;
  end

  periph_event_model model_u (.aclk(aclk), .aresetn(aresetn), .fire(fire), .cmd(cmd), .pulse(pulse),
    .rx_not_empty(rx_ne), .tx_has_room(tx_room), .tx_shift_empty(tx_se));

  peripheral_irq_flag_bank dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .zero_cross_rise(pulse[0]),
    .zero_cross_fall(pulse[1]), .comparator_a_event(pulse[2]), .comparator_b_event(pulse[3]),
    .uart_a_rx_not_empty(rx_ne[0]), .uart_b_rx_not_empty(rx_ne[1]), .uart_a_tx_has_room(tx_room[0]),
    .uart_b_tx_has_room(tx_room[1]), .uart_a_tx_shift_empty(tx_se[0]), .uart_b_tx_shift_empty(tx_se[1]),
    .sync_port_a_collision(pulse[4]), .sync_port_a_done(pulse[5]), .sync_port_b_collision(pulse[6]),
    .sync_port_b_done(pulse[7]), .period_match(pulse[8]), .postscaler_overflow(pulse[9]),
    .postscale_one_to_one(os), .wide_timer_overflow(pulse[10]), .timer_gate_active(gate),
    .logic_cell_event(pulse[20:17]), .capcmp_a_mode(mode), .capcmp_a_capture(pulse[11]),
    .capcmp_a_match(pulse[12]), .capcmp_a_trailing_edge(pulse[13]), .capcmp_b_mode(mode),
    .capcmp_b_capture(pulse[14]), .capcmp_b_match(pulse[15]), .capcmp_b_trailing_edge(pulse[16]), .irq(irq));

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  // Handshakes are judged at the falling edge, released after the next rising one
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      bad_count++;
      final_report();
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin
      bad_count++;
      final_report();
    end
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk({30'h0, r}, {30'h0, `RESP_OKAY});
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, e);
  endtask : rd_chk

  task automatic hit(input int e);
    @(posedge aclk);
    fire <= 21'h1 << e;
    @(posedge aclk);
    fire <= 21'h0;
  endtask : hit

  task automatic bufc(input int b);
    @(posedge aclk);
    cmd <= 8'h1 << b;
    @(posedge aclk);
    cmd <= 8'h00;
  endtask : bufc

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  task automatic flags_clear;
    for (int i = 0; i < 5; i++) begin
      rd_chk(8'(4 * i), (i == 1) ? 32'h50 : 32'h0);
    end
    chk({31'h0, irq}, 32'h0);
  endtask : flags_clear

  task automatic irq_case(input logic [31:0] ctl, input logic [31:0] mask, input logic [31:0] exp);
    wr(`ADDR_CONTROL, ctl);
    wr(`ADDR_EVENT_MASK, mask);
    hit(2);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk({31'h0, irq}, exp);
    rd_chk(`ADDR_EVENT_STATUS, 32'h1);
    @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(8'h00, 32'h0);
  endtask : irq_case

  initial begin
    logic [23:0] c;
    logic [31:0] d, rx, tx;
    logic [1:0] r;
    do_reset();
    flags_clear();
    wr(`ADDR_CONTROL, 32'h7);
    for (int i = 0; i < 24; i++) begin
      c = CASES[i];
      @(posedge aclk);
      mode <= capcmp_mode_t'(c[18:17]);
      os <= c[16];
      hit(int'(c[23:19]));
      rd_chk(c[15:8], {24'h0, c[7:0]});
      wr(c[15:8], 32'h0);
      rd_chk(c[15:8], (c[15:8] == 8'h04) ? 32'h50 : 32'h0);
    end
    @(posedge aclk);
    gate <= 1'b1;
    rd_chk(8'h0c, 32'h0);
    gate <= 1'b0;
    rd_chk(8'h0c, 32'h1);
    wr(8'h0c, 32'h0);
    // Clear lands at the edge where the second pulse is sampled: comparator, then collision
    for (int j = 0; j < 2; j++) begin
      hit(j ? 4 : 2);
      fork
        wr(8'(4 * j), 32'h0);
        begin
          @(posedge aclk);
          hit(j ? 4 : 2);
        end
      join
      rd_chk(8'(4 * j), j ? 32'h52 : 32'h1);
      wr(8'(4 * j), 32'h0);
    end
    for (int p = 0; p < 2; p++) begin
      rx = p ? 32'h80 : 32'h20;
      tx = p ? 32'h40 : 32'h10;
      rd_chk(`ADDR_SERIAL_STATUS, 32'h3);
      bufc(p);
      bufc(p);
      rd_chk(8'h04, 32'h50 | rx);
      wr(8'h04, 32'h0);
      bufc(p + 2);
      rd_chk(8'h04, 32'h50 | rx);
      bufc(p + 2);
      rd_chk(8'h04, 32'h50);
      for (int k = 0; k < 2; k++) begin
        rd_chk(8'h04, 32'h50);
        bufc(p + 4);
        rd_chk(`ADDR_SERIAL_STATUS, 32'h3 ^ (32'h1 << p));
      end
      rd_chk(8'h04, 32'h50 ^ tx);
      bufc(p + 6);
      bufc(p + 6);
      rd_chk(8'h04, 32'h50);
    end
    wr(`ADDR_ENABLE_BASE, 32'h1);
    irq_case(32'h7, 32'h1, 32'h1);
    irq_case(32'h7, 32'h0, 32'h0);
    irq_case(32'h6, 32'h1, 32'h0);
    axi_rd(8'h3c, d, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    chk(d, 32'h0);
    axi_wr(8'h80, 32'hff, r);
    chk({30'h0, r}, {30'h0, `RESP_SLVERR});
    for (int i = 0; i < 5; i++) begin
      wr(8'(4 * i), 32'hff);
      rd_chk(8'(4 * i), {24'h0, WR_EXP[i]});
    end
    @(posedge aclk);
    do_reset();
    flags_clear();
    final_report();
  end
endmodule : peripheral_irq_flag_bank_bench
`default_nettype wire
